// ===== hdl/dcbf_pkg.sv
package dcbf_pkg;

   localparam int          DCBF_WIDTH        = 36;
   localparam int          DCBF_DEPTH        = 512;
   localparam int          DCBF_OFF_W        = 9;
   localparam logic [8:0]  DCBF_PRESET_HH    = 9'h040;
   localparam logic [8:0]  DCBF_PRESET_HL    = 9'h010;
   localparam logic [8:0]  DCBF_PRESET_LH    = 9'h008;
   localparam logic [8:0]  DCBF_OFFSET_RESET = 9'h040;
   localparam logic [1:0]  DCBF_IR_DELAY     = 2'h2;
   localparam logic [1:0]  DCBF_PROG_FIRST   = 2'h0;
   localparam logic [1:0]  DCBF_PROG_LAST    = 2'h3;
   localparam int          DCBF_Q_AB         = 0;
   localparam int          DCBF_Q_BA         = 1;

   typedef enum logic [1:0] {
      DCBF_PROG_IDLE = 2'b01,
      DCBF_PROG_LOAD = 2'b10
   } dcbf_prog_type;

   // select pair {hi,lo}; 2'b00 means offsets come from port A writes
   function automatic logic [8:0] dcbf_preset(input logic [1:0] sel);
      case (sel)
         2'b11:   return DCBF_PRESET_HH;
         2'b10:   return DCBF_PRESET_HL;
         2'b01:   return DCBF_PRESET_LH;
         default: return DCBF_OFFSET_RESET;
      endcase
   endfunction : dcbf_preset

endpackage : dcbf_pkg

// ===== hdl/dcbf_top.sv
// Notes on behaviour
// - queue resets may change at any time
// - reset clears pointers, ready and empty flags, sets full and box flags
// - space ready rises two writer edges later
// - reset rising edge captures offset selects
// - selects 11/10/01 load 64/16/8
// - queues reset together or apart with presets
// - both resets with selects low enter programming
// - program order ab full, ab empty, ba full, ba empty
// - offset from port A bits 8..0, 1..508
// - fourth offset releases b_to_a space ready
// - port A driven only selected and reading
// - port A write stores into a_to_b queue
// - port A read advances b_to_a queue
// - port A and port B work independently, except port B b_to_a writes wait for programming
// - port B direction select is inverted
// - port B driven only selected and reading
// - port B write stores into b_to_a queue
// - port B read advances a_to_b queue
// - empty output register fills on third edge
// - full output register reloads only on read
// - output ready passes two stages of reader clock, other flags one stage of reader/writer clock
// - output ready low on reset, third edge rise
// - box select routes access to mailboxes
// - box write lowers flag, far read raises it
// - almost empty low at or below empty offset
// - almost full low when room at most offset
`timescale 1ns/1ps
`default_nettype none

module dcbf_queue
   import dcbf_pkg::*;
#(
   parameter int DEPTH = DCBF_DEPTH,
   parameter int WIDTH = DCBF_WIDTH
) (
   input  wire logic                  i_clock,
   input  wire logic                  i_arst_n,
   input  wire logic                  i_qrst,
   input  wire logic                  i_wr_edge,
   input  wire logic                  i_rd_edge,
   input  wire logic                  i_wr_req,
   input  wire logic                  i_rd_req,
   input  wire logic                  i_hold,
   input  wire logic [WIDTH-1:0]      i_wr_data,
   input  wire logic [DCBF_OFF_W-1:0] i_empty_offset,
   input  wire logic [DCBF_OFF_W-1:0] i_full_offset,
   output logic                       o_space_ready,
   output logic                       o_output_ready,
   output logic                       o_almost_empty_n,
   output logic                       o_almost_full_n,
   output logic [WIDTH-1:0]           o_word
);
   localparam int AW = $clog2(DEPTH);
   localparam int PW = AW + 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wptr_reg;
   logic [PW-1:0]    rptr_reg;
   logic [PW-1:0]    rptr_s1_reg;
   logic [PW-1:0]    wptr_s1_reg;
   logic [PW-1:0]    wptr_s2_reg;
   logic [1:0]       ir_cnt_reg;
   logic [PW-1:0]    wptr_next;
   logic [PW-1:0]    rptr_next;
   logic [PW-1:0]    room;
   logic             wr_do;
   logic             shift;

   function automatic logic [PW-1:0] fill(input logic [PW-1:0] w, input logic [PW-1:0] r);
      return w - r;
   endfunction : fill

   assign wr_do     = i_wr_edge & i_wr_req & o_space_ready & ~i_qrst;
   assign wptr_next = wptr_reg + PW'(wr_do);
   assign room      = PW'(DEPTH) - fill(wptr_next, rptr_s1_reg);
   // the word in the output register no longer counts as stored
   assign shift     = (wptr_s2_reg != rptr_reg) & (~o_output_ready | i_rd_req);
   assign rptr_next = rptr_reg + PW'(shift);

   always_ff @(posedge i_clock) begin
      if (wr_do) begin
         mem[wptr_reg[AW-1:0]] <= i_wr_data;
      end
   end

   // writer side: space ready and almost full follow the writer's port edges
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wptr_reg        <= '0;
         rptr_s1_reg     <= '0;
         ir_cnt_reg      <= DCBF_IR_DELAY;
         o_space_ready   <= 1'b0;
         o_almost_full_n <= 1'b1;
      end else if (i_qrst) begin
         wptr_reg        <= '0;
         rptr_s1_reg     <= '0;
         ir_cnt_reg      <= DCBF_IR_DELAY;
         o_space_ready   <= 1'b0;
         o_almost_full_n <= 1'b1;
      end else if (i_wr_edge) begin
         wptr_reg    <= wptr_next;
         rptr_s1_reg <= rptr_reg;
         if (ir_cnt_reg != 2'h0) begin
            ir_cnt_reg <= ir_cnt_reg - 2'h1;
         end
         o_space_ready   <= (ir_cnt_reg <= 2'h1) & ~i_hold & (room != '0);
         o_almost_full_n <= room > PW'(i_full_offset);
      end
   end

   // reader side: output register, output ready and almost empty
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rptr_reg         <= '0;
         wptr_s1_reg      <= '0;
         wptr_s2_reg      <= '0;
         o_output_ready   <= 1'b0;
         o_almost_empty_n <= 1'b0;
         o_word           <= '0;
      end else if (i_qrst) begin
         rptr_reg         <= '0;
         wptr_s1_reg      <= '0;
         wptr_s2_reg      <= '0;
         o_output_ready   <= 1'b0;
         o_almost_empty_n <= 1'b0;
      end else if (i_rd_edge) begin
         wptr_s1_reg <= wptr_reg;
         wptr_s2_reg <= wptr_s1_reg;
         if (shift) begin
            o_word         <= mem[rptr_reg[AW-1:0]];
            rptr_reg       <= rptr_next;
            o_output_ready <= 1'b1;
         end else if (i_rd_req) begin
            o_output_ready <= 1'b0;
         end
         o_almost_empty_n <= fill(wptr_s1_reg, rptr_next) > PW'(i_empty_offset);
      end
   end

   a_ready_delay: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (ir_cnt_reg == DCBF_IR_DELAY) |-> !o_space_ready)
      else $error("space ready high before two writer edges");

   a_full_stall: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (!o_space_ready && !i_qrst) |=> (wptr_reg == $past(wptr_reg)))
      else $error("write accepted while space ready low");

   a_or_shift: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      $rose(o_output_ready) |-> (rptr_reg != $past(rptr_reg)))
      else $error("output ready rose without loading a word");

endmodule : dcbf_queue

module dcbf_top
   import dcbf_pkg::*;
#(
   parameter int DEPTH = DCBF_DEPTH,
   parameter int WIDTH = DCBF_WIDTH
) (
   input  wire logic             i_clock,
   input  wire logic             i_arst_n,
   input  wire logic             i_port_a_clock,
   input  wire logic             i_port_b_clock,
   input  wire logic             i_a_to_b_reset_n,
   input  wire logic             i_b_to_a_reset_n,
   input  wire logic             i_offset_select_hi,
   input  wire logic             i_offset_select_lo,
   input  wire logic             i_port_a_select_n,
   input  wire logic             i_port_a_write_not_read,
   input  wire logic             i_port_a_gate,
   input  wire logic             i_port_a_box_select,
   input  wire logic [WIDTH-1:0] i_port_a_bus,
   output logic      [WIDTH-1:0] o_port_a_bus,
   output logic                  o_port_a_bus_oe,
   input  wire logic             i_port_b_select_n,
   input  wire logic             i_port_b_read_not_write,
   input  wire logic             i_port_b_gate,
   input  wire logic             i_port_b_box_select,
   input  wire logic [WIDTH-1:0] i_port_b_bus,
   output logic      [WIDTH-1:0] o_port_b_bus,
   output logic                  o_port_b_bus_oe,
   output logic                  o_a_to_b_space_ready,
   output logic                  o_a_to_b_almost_full_n,
   output logic                  o_b_to_a_output_ready,
   output logic                  o_b_to_a_almost_empty_n,
   output logic                  o_b_to_a_space_ready,
   output logic                  o_b_to_a_almost_full_n,
   output logic                  o_a_to_b_output_ready,
   output logic                  o_a_to_b_almost_empty_n,
   output logic                  o_a_to_b_box_flag_n,
   output logic                  o_b_to_a_box_flag_n
);
   logic [1:0]            rst_meta_reg;
   logic [1:0]            rst_sync_reg;
   logic [1:0]            rst_prev_reg;
   logic [1:0]            clk_prev_reg;
   logic [1:0]            qrst;
   logic [1:0]            rst_rise;
   logic [1:0]            sel;
   logic                  a_edge;
   logic                  b_edge;
   logic                  a_wr_sel;
   logic                  a_rd_sel;
   logic                  b_wr_sel;
   logic                  b_rd_sel;
   logic                  prog_wr;
   dcbf_prog_type         prog_reg;
   logic [1:0]            prog_idx_reg;
   logic [DCBF_OFF_W-1:0] ab_empty_offset_reg;
   logic [DCBF_OFF_W-1:0] ab_full_offset_reg;
   logic [DCBF_OFF_W-1:0] ba_empty_offset_reg;
   logic [DCBF_OFF_W-1:0] ba_full_offset_reg;
   logic [WIDTH-1:0]      box_a_to_b_reg;
   logic [WIDTH-1:0]      box_b_to_a_reg;
   logic [WIDTH-1:0]      ab_word;
   logic [WIDTH-1:0]      ba_word;

   // resets arrive unaligned; two flops before anything looks at them
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_meta_reg <= 2'h0;
         rst_sync_reg <= 2'h0;
         rst_prev_reg <= 2'h0;
      end else begin
         rst_meta_reg <= {i_b_to_a_reset_n, i_a_to_b_reset_n};
         rst_sync_reg <= rst_meta_reg;
         rst_prev_reg <= rst_sync_reg;
      end
   end

   assign qrst     = ~rst_sync_reg;
   assign rst_rise = rst_sync_reg & ~rst_prev_reg;
   assign sel      = {i_offset_select_hi, i_offset_select_lo};

   // port clocks are sampled; a port cycle is a rising edge seen here
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         clk_prev_reg <= 2'h0;
      end else begin
         clk_prev_reg <= {i_port_b_clock, i_port_a_clock};
      end
   end

   assign a_edge   = i_port_a_clock & ~clk_prev_reg[0];
   assign b_edge   = i_port_b_clock & ~clk_prev_reg[1];
   assign a_wr_sel = ~i_port_a_select_n & i_port_a_gate & i_port_a_write_not_read;
   assign a_rd_sel = ~i_port_a_select_n & i_port_a_gate & ~i_port_a_write_not_read;
   assign b_wr_sel = ~i_port_b_select_n & i_port_b_gate & ~i_port_b_read_not_write;
   assign b_rd_sel = ~i_port_b_select_n & i_port_b_gate & i_port_b_read_not_write;
   assign prog_wr  = (prog_reg == DCBF_PROG_LOAD) & a_edge & a_wr_sel & ~i_port_a_box_select
                     & o_a_to_b_space_ready;

   // offsets: presets latched on reset release, or four port A writes
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         prog_reg            <= DCBF_PROG_IDLE;
         prog_idx_reg        <= DCBF_PROG_FIRST;
         ab_empty_offset_reg <= DCBF_OFFSET_RESET;
         ab_full_offset_reg  <= DCBF_OFFSET_RESET;
         ba_empty_offset_reg <= DCBF_OFFSET_RESET;
         ba_full_offset_reg  <= DCBF_OFFSET_RESET;
      end else begin
         if (rst_rise[DCBF_Q_AB] && sel != 2'b00) begin
            ab_empty_offset_reg <= dcbf_preset(sel);
            ab_full_offset_reg  <= dcbf_preset(sel);
         end
         if (rst_rise[DCBF_Q_BA] && sel != 2'b00) begin
            ba_empty_offset_reg <= dcbf_preset(sel);
            ba_full_offset_reg  <= dcbf_preset(sel);
         end
         case (prog_reg)
            DCBF_PROG_IDLE: begin
               if (rst_rise == 2'b11 && sel == 2'b00) begin
                  prog_reg     <= DCBF_PROG_LOAD;
                  prog_idx_reg <= DCBF_PROG_FIRST;
               end
            end
            DCBF_PROG_LOAD: begin
               if (qrst != 2'b00) begin
                  prog_reg <= DCBF_PROG_IDLE;
               end else if (prog_wr) begin
                  case (prog_idx_reg)
                     2'h0:    ab_full_offset_reg  <= i_port_a_bus[DCBF_OFF_W-1:0];
                     2'h1:    ab_empty_offset_reg <= i_port_a_bus[DCBF_OFF_W-1:0];
                     2'h2:    ba_full_offset_reg  <= i_port_a_bus[DCBF_OFF_W-1:0];
                     default: ba_empty_offset_reg <= i_port_a_bus[DCBF_OFF_W-1:0];
                  endcase
                  prog_idx_reg <= prog_idx_reg + 2'h1;
                  if (prog_idx_reg == DCBF_PROG_LAST) begin
                     prog_reg <= DCBF_PROG_IDLE;
                  end
               end
            end
            default: prog_reg <= DCBF_PROG_IDLE;
         endcase
      end
   end

   // mailboxes bypass the queues; a new write wins over a same-cycle read
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         box_a_to_b_reg      <= '0;
         o_a_to_b_box_flag_n <= 1'b1;
      end else if (qrst[DCBF_Q_AB]) begin
         o_a_to_b_box_flag_n <= 1'b1;
      end else if (a_edge && a_wr_sel && i_port_a_box_select && o_a_to_b_box_flag_n) begin
         box_a_to_b_reg      <= i_port_a_bus;
         o_a_to_b_box_flag_n <= 1'b0;
      end else if (b_edge && b_rd_sel && i_port_b_box_select) begin
         o_a_to_b_box_flag_n <= 1'b1;
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         box_b_to_a_reg      <= '0;
         o_b_to_a_box_flag_n <= 1'b1;
      end else if (qrst[DCBF_Q_BA]) begin
         o_b_to_a_box_flag_n <= 1'b1;
      end else if (b_edge && b_wr_sel && i_port_b_box_select && o_b_to_a_box_flag_n) begin
         box_b_to_a_reg      <= i_port_b_bus;
         o_b_to_a_box_flag_n <= 1'b0;
      end else if (a_edge && a_rd_sel && i_port_a_box_select) begin
         o_b_to_a_box_flag_n <= 1'b1;
      end
   end

   // the queues run on separate port edges, so ports wait on each other only while port A programs offsets
   dcbf_queue #(.DEPTH(DEPTH), .WIDTH(WIDTH)) u_queue_a_to_b (
      .i_clock          (i_clock),
      .i_arst_n         (i_arst_n),
      .i_qrst           (qrst[DCBF_Q_AB]),
      .i_wr_edge        (a_edge),
      .i_rd_edge        (b_edge),
      .i_wr_req         (a_wr_sel & ~i_port_a_box_select & (prog_reg != DCBF_PROG_LOAD)),
      .i_rd_req         (b_rd_sel & ~i_port_b_box_select),
      .i_hold           (1'b0),
      .i_wr_data        (i_port_a_bus),
      .i_empty_offset   (ab_empty_offset_reg),
      .i_full_offset    (ab_full_offset_reg),
      .o_space_ready    (o_a_to_b_space_ready),
      .o_output_ready   (o_a_to_b_output_ready),
      .o_almost_empty_n (o_a_to_b_almost_empty_n),
      .o_almost_full_n  (o_a_to_b_almost_full_n),
      .o_word           (ab_word)
   );

   dcbf_queue #(.DEPTH(DEPTH), .WIDTH(WIDTH)) u_queue_b_to_a (
      .i_clock          (i_clock),
      .i_arst_n         (i_arst_n),
      .i_qrst           (qrst[DCBF_Q_BA]),
      .i_wr_edge        (b_edge),
      .i_rd_edge        (a_edge),
      .i_wr_req         (b_wr_sel & ~i_port_b_box_select),
      .i_rd_req         (a_rd_sel & ~i_port_a_box_select),
      .i_hold           (prog_reg == DCBF_PROG_LOAD),
      .i_wr_data        (i_port_b_bus),
      .i_empty_offset   (ba_empty_offset_reg),
      .i_full_offset    (ba_full_offset_reg),
      .o_space_ready    (o_b_to_a_space_ready),
      .o_output_ready   (o_b_to_a_output_ready),
      .o_almost_empty_n (o_b_to_a_almost_empty_n),
      .o_almost_full_n  (o_b_to_a_almost_full_n),
      .o_word           (ba_word)
   );

   // bus drive registered for clean outputs, so it trails the selects by one cycle
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_port_a_bus_oe <= 1'b0;
         o_port_a_bus    <= '0;
         o_port_b_bus_oe <= 1'b0;
         o_port_b_bus    <= '0;
      end else begin
         o_port_a_bus_oe <= ~i_port_a_select_n & ~i_port_a_write_not_read;
         o_port_a_bus    <= i_port_a_box_select ? box_b_to_a_reg : ba_word;
         o_port_b_bus_oe <= ~i_port_b_select_n & i_port_b_read_not_write;
         o_port_b_bus    <= i_port_b_box_select ? box_a_to_b_reg : ab_word;
      end
   end

   a_a_drive: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (i_port_a_select_n || i_port_a_write_not_read) |=> !o_port_a_bus_oe)
      else $error("port A driven while not selected for read");

   a_b_drive: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (!i_port_b_select_n && i_port_b_read_not_write) |=> o_port_b_bus_oe)
      else $error("port B not driven during selected read");

   a_reset_flags: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      qrst[DCBF_Q_AB] |=> (!o_a_to_b_space_ready && !o_a_to_b_output_ready
                           && !o_a_to_b_almost_empty_n && o_a_to_b_almost_full_n
                           && o_a_to_b_box_flag_n))
      else $error("a_to_b queue flags wrong under reset");

   a_box_write: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (a_edge && a_wr_sel && i_port_a_box_select && o_a_to_b_box_flag_n && !qrst[DCBF_Q_AB])
      |=> (!o_a_to_b_box_flag_n && box_a_to_b_reg == $past(i_port_a_bus)))
      else $error("mailbox write did not store or lower flag");

   a_preset_load: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (rst_rise[DCBF_Q_AB] && sel == 2'b11)
      |=> (ab_empty_offset_reg == 9'h040 && ab_full_offset_reg == 9'h040))
      else $error("preset 64 not loaded on reset release");

   a_prog_hold: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (prog_reg == DCBF_PROG_LOAD && !qrst[DCBF_Q_BA]) |=> !o_b_to_a_space_ready)
      else $error("b_to_a space ready high during programming");

endmodule : dcbf_top
`default_nettype wire

// ===== verification/dcbf_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module dcbf_far_side
   import dcbf_pkg::*;
(
   input  wire logic                  i_clock,
   input  wire logic                  i_a_oe,
   input  wire logic [DCBF_WIDTH-1:0] i_a_dev,
   input  wire logic [DCBF_WIDTH-1:0] i_a_host,
   input  wire logic                  i_b_oe,
   input  wire logic [DCBF_WIDTH-1:0] i_b_dev,
   input  wire logic [DCBF_WIDTH-1:0] i_b_host,
   output logic                       o_port_a_clock,
   output logic                       o_port_b_clock,
   output logic      [DCBF_WIDTH-1:0] o_a_bus,
   output logic      [DCBF_WIDTH-1:0] o_b_bus
);
   logic [2:0] a_cnt = 3'h0;
   logic [2:0] b_cnt = 3'h1;
   initial o_port_a_clock = 1'b0;
   initial o_port_b_clock = 1'b0;
   // unequal ratios keep the two port clocks sliding against each other
   always @(posedge i_clock) begin
      a_cnt <= (a_cnt == 3'h2) ? 3'h0 : a_cnt + 3'h1;
      b_cnt <= (b_cnt == 3'h3) ? 3'h0 : b_cnt + 3'h1;
      if (a_cnt == 3'h2) o_port_a_clock <= ~o_port_a_clock;
      if (b_cnt == 3'h3) o_port_b_clock <= ~o_port_b_clock;
   end
   // the host lets go of a bus while the device drives it
   assign o_a_bus = i_a_oe ? i_a_dev : i_a_host;
   assign o_b_bus = i_b_oe ? i_b_dev : i_b_host;
endmodule : dcbf_far_side
`default_nettype wire

// ===== verification/tb_dcbf_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dcbf_top
   import dcbf_pkg::*;
();
   logic        clk;
   logic        arst_n = 1'b0;
   logic        fs_hi  = 1'b0;
   logic        fs_lo  = 1'b0;
   logic [1:0]  qrst_n = 2'h0;
   logic [1:0]  sel_n  = 2'h3;
   logic [1:0]  dirs   = 2'h0;
   logic [1:0]  gate   = 2'h0;
   logic [1:0]  box    = 2'h0;
   logic [1:0]  oe;
   logic [1:0]  pclk;
   // flags by pair, index 0 for a_to_b: space, output, empty, full, box
   logic [9:0]  fl;
   logic [8:0]  offs [4] = '{9'h1F4, 9'h002, 9'h1FC, 9'h001};
   logic [35:0] host [2] = '{36'h0, 36'h0};
   logic [35:0] dev [2];
   logic [35:0] bus [2];
   logic [35:0] q;
   int          err_total = 0;
   int          total_checks = 0;
   dcbf_top dut (
      .i_clock(clk), .i_arst_n(arst_n), .i_port_a_clock(pclk[0]), .i_port_b_clock(pclk[1]),
      .i_a_to_b_reset_n(qrst_n[0]), .i_b_to_a_reset_n(qrst_n[1]),
      .i_offset_select_hi(fs_hi), .i_offset_select_lo(fs_lo),
      .i_port_a_select_n(sel_n[0]), .i_port_a_write_not_read(dirs[0]), .i_port_a_gate(gate[0]),
      .i_port_a_box_select(box[0]), .i_port_a_bus(bus[0]), .o_port_a_bus(dev[0]), .o_port_a_bus_oe(oe[0]),
      .i_port_b_select_n(sel_n[1]), .i_port_b_read_not_write(dirs[1]), .i_port_b_gate(gate[1]),
      .i_port_b_box_select(box[1]), .i_port_b_bus(bus[1]), .o_port_b_bus(dev[1]), .o_port_b_bus_oe(oe[1]),
      .o_a_to_b_space_ready(fl[0]), .o_b_to_a_space_ready(fl[1]), .o_a_to_b_output_ready(fl[2]),
      .o_b_to_a_output_ready(fl[3]), .o_a_to_b_almost_empty_n(fl[4]), .o_b_to_a_almost_empty_n(fl[5]),
      .o_a_to_b_almost_full_n(fl[6]), .o_b_to_a_almost_full_n(fl[7]),
      .o_a_to_b_box_flag_n(fl[8]), .o_b_to_a_box_flag_n(fl[9]));
   dcbf_far_side partner (
      .i_clock(clk), .i_a_oe(oe[0]), .i_a_dev(dev[0]), .i_a_host(host[0]), .o_a_bus(bus[0]),
      .i_b_oe(oe[1]), .i_b_dev(dev[1]), .i_b_host(host[1]), .o_b_bus(bus[1]),
      .o_port_a_clock(pclk[0]), .o_port_b_clock(pclk[1]));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
      end
   endtask : chk_bit
   task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t word %h expected %h", $time, got, exp);
      end
   endtask : chk_word
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : complete_run
   task automatic wait_flag(input int k);
      for (int n = 0; fl[k] !== 1'b1; n++) begin
         if (n == 400) begin
            err_total++;
            $display("[FAIL] %0t flag %0d never rose", $time, k);
            complete_run();
         end
         @(posedge clk);
      end
   endtask : wait_flag
   // request held from a port clock low phase until the device has sampled the rising edge
   task automatic port_op(input int p, input logic d_in, input logic bx, input logic [35:0] d);
      @(negedge pclk[p]);
      @(posedge clk);
      sel_n[p] <= 1'b0;
      dirs[p] <= d_in;
      gate[p] <= 1'b1;
      box[p] <= bx;
      host[p] <= d;
      @(posedge pclk[p]);
      q = bus[p];
      chk_bit(oe[p], d_in ^ (p == 0));
      @(posedge clk);
      sel_n[p] <= 1'b1;
      gate[p] <= 1'b0;
      host[p] <= ~d;
   endtask : port_op
   task automatic qreset(input logic [1:0] m, input logic hi, input logic lo);
      fs_hi <= hi;
      fs_lo <= lo;
      qrst_n <= qrst_n & ~m;
      repeat (40) @(posedge clk);
      for (int k = 0; k < 10; k++) begin
         if (m[k % 2]) chk_bit(fl[k], k >= 6);
      end
      qrst_n <= qrst_n | m;
   endtask : qreset
   initial begin
      repeat (100000) @(posedge clk);
      err_total++;
      $display("[FAIL] %0t run did not finish", $time);
      complete_run();
   end
   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      qreset(2'h3, 1'b0, 1'b0);
      wait_flag(0);
      chk_bit(fl[1], 1'b0);
      foreach (offs[i]) port_op(0, 1'b1, 1'b0, {27'h5A5A5A5, offs[i]});
      wait_flag(1);
      $display("test programming done");
      for (int i = 0; i < 13; i++) begin
         port_op(0, 1'b1, 1'b0, 36'h1_0000_0000 + 36'(i));
         if (i == 2 || i == 3 || i == 11 || i == 12) begin
            repeat (40) @(posedge clk);
            chk_bit(i < 4 ? fl[4] : fl[6], i == 3 || i == 11);
         end
      end
      for (int i = 0; i < 13; i++) begin
         wait_flag(2);
         port_op(1, 1'b1, 1'b0, 36'h0);
         chk_word(q, 36'h1_0000_0000 + 36'(i));
      end
      repeat (40) @(posedge clk);
      chk_bit(fl[2], 1'b0);
      $display("test a_to_b stream done");
      fork
         for (int i = 0; i < 3; i++) port_op(1, 1'b0, 1'b0, 36'hB_0000_0000 + 36'(i));
         for (int i = 0; i < 2; i++) port_op(0, 1'b1, 1'b0, 36'hA_0000_0000 + 36'(i));
      join
      repeat (40) @(posedge clk);
      chk_bit(fl[5], 1'b1);
      chk_bit(fl[7], 1'b1);
      for (int i = 0; i < 3; i++) begin
         port_op(0, 1'b0, 1'b0, 36'h0);
         chk_word(q, 36'hB_0000_0000 + 36'(i));
      end
      for (int i = 0; i < 2; i++) begin
         port_op(1, 1'b1, 1'b0, 36'h0);
         chk_word(q, 36'hA_0000_0000 + 36'(i));
      end
      repeat (4) @(posedge clk);
      chk_bit(fl[3], 1'b0);
      $display("test both directions done");
      port_op(0, 1'b1, 1'b1, 36'hC_1234_5678);
      port_op(0, 1'b1, 1'b1, 36'hD_0000_0000);
      chk_bit(fl[8], 1'b0);
      port_op(1, 1'b1, 1'b1, 36'h0);
      chk_word(q, 36'hC_1234_5678);
      repeat (4) @(posedge clk);
      chk_bit(fl[8], 1'b1);
      chk_bit(fl[2], 1'b0);
      port_op(0, 1'b1, 1'b1, 36'hE_0000_0000);
      port_op(1, 1'b0, 1'b1, 36'h9_8765_4321);
      repeat (2) @(posedge clk);
      chk_bit(fl[9], 1'b0);
      port_op(0, 1'b0, 1'b1, 36'h0);
      chk_word(q, 36'h9_8765_4321);
      repeat (4) @(posedge clk);
      chk_bit(fl[9], 1'b1);
      $display("test mailbox done");
      for (int s = 3; s > 0; s--) begin
         int off;
         off = (s == 3) ? 64 : (s == 2) ? 16 : 8;
         qreset(2'h1, s[1], s[0]);
         wait_flag(0);
         for (int i = 0; i <= off; i++) port_op(0, 1'b1, 1'b0, 36'(i));
         repeat (40) @(posedge clk);
         chk_bit(fl[4], 1'b0);
         port_op(0, 1'b1, 1'b0, 36'h0);
         repeat (40) @(posedge clk);
         chk_bit(fl[4], 1'b1);
      end
      $display("test presets done");
      complete_run();
   end
endmodule : tb_dcbf_top
`default_nettype wire
